// ### test/eetw_bm.sv
// Bus master model: bits, START, STOP at 16 clocks a bit.
// Assumes a 10 MHz clk_in and a pulled-up SDA in the bench.
`timescale 1ns/10ps
module eetw_bm (
  input wire clk_in,
  input wire sda_in,
  output reg scl_out,
  output reg sda_low_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task bit_io(input l, output r);
    begin
      @(posedge clk_in);
      scl_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      sda_low_out <= l;
      repeat (4) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (7) @(posedge clk_in);
      r = sda_in;
    end
  endtask
  // Spare pulse first: the very first fall wakes the mode
  task start;
    reg r;
    begin
      bit_io(1'b0, r);
      @(posedge clk_in);
      sda_low_out <= 1'b1;
      repeat (7) @(posedge clk_in);
    end
  endtask
  task stop;
    reg r;
    begin
      bit_io(1'b1, r);
      @(posedge clk_in);
      sda_low_out <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
  endtask
  task wbyte(input [7:0] b, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(~b[i], r);
      bit_io(1'b0, r);
      ack = ~r;
    end
  endtask
  task rbyte(input ackm, output [7:0] b);
    integer i;
    reg r;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        bit_io(1'b0, r);
        b = {b[6:0], r};
      end
      bit_io(ackm, r);
    end
  endtask
endmodule // eetw_bm

// ### test/eetw_slave_asserts.sv
// Checker for eetw_slave: bus drive, write timing, sticky state.
// Bound to every eetw_slave; sees its ports only.
`timescale 1ns/10ps
module eetw_slave_asserts #(parameter WRITE_CYCLES = 100000) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic transmit_only_clock_in,
  input wire logic wp_n_in,
  input wire logic [7:0] arr_rd_data_in,
  input wire logic [6:0] arr_rd_addr_out,
  input wire logic arr_wr_en_out,
  input wire logic [6:0] arr_wr_addr_out,
  input wire logic [7:0] arr_wr_data_out,
  input wire logic bidir_mode_out,
  input wire logic busy_out,
  input wire logic fuse_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [31:0] bcnt_q;
  always @(posedge clk_in) bcnt_q <= (rst_in || !busy_out) ? 32'h0 : bcnt_q + 32'h1;
  property p_oe_chg;
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_chg: assert property (p_oe_chg) else $error("drive moved, scl high");
  property p_busy_quiet;
    busy_out |-> !sda_oe_out;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
  property p_oe_hold;
    $rose(sda_oe_out) |-> (sda_oe_out && !sda_out) [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("short low drive");
  property p_wr_busy;
    arr_wr_en_out |-> busy_out;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("commit outside write");
  property p_busy_rise;
    $rose(busy_out) |-> scl_in && sda_in;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("write without stop");
  property p_busy_len;
    $fell(busy_out) |-> bcnt_q >= WRITE_CYCLES - 2 && bcnt_q <= WRITE_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time off");
  property p_mode;
    bidir_mode_out |=> bidir_mode_out;
  endproperty
  a_mode: assert property (p_mode) else $error("mode dropped");
  property p_fuse;
    $rose(fuse_out) |-> busy_out && arr_wr_addr_out == 7'h7f;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse without 7f");
  c_busy: cover property ($rose(busy_out));
  c_wr: cover property (arr_wr_en_out);
  c_fuse: cover property ($rose(fuse_out));
endmodule // eetw_slave_asserts
bind eetw_slave eetw_slave_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) eetw_chk (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .transmit_only_clock_in(transmit_only_clock_in),
  .wp_n_in(wp_n_in),
  .arr_rd_data_in(arr_rd_data_in),
  .arr_rd_addr_out(arr_rd_addr_out),
  .arr_wr_en_out(arr_wr_en_out),
  .arr_wr_addr_out(arr_wr_addr_out),
  .arr_wr_data_out(arr_wr_data_out),
  .bidir_mode_out(bidir_mode_out),
  .busy_out(busy_out),
  .fuse_out(fuse_out)
);

// ### test/eetw_slave_tb.sv
// Bench for eetw_slave: random writes, reads, write protection.
// Bus from eetw_bm; a 128-byte array model answers one clock late.
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks = checks + 1; if ((a) !== (e)) begin fails = fails + 1; \
  $display("FAIL %s exp %h got %h", n, e, a); end end
module eetw_slave_tb;
  localparam [6:0] DEV = 7'h2b; // Arbitrary bus address
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg txoc = 1'b1;
  reg wp_n = 1'b1;
  reg [7:0] arr_q [0:127];
  reg [7:0] exp_mem [0:127];
  reg [7:0] rd_q = 8'h00;
  reg [7:0] ptr = 8'h00;
  reg [7:0] r8;
  reg efuse = 1'b0;
  reg ak;
  integer seed = 32'h989f6678;
  integer fails = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i;
  wire scl, m_low, oe, sda_o, we, bidir, busy, fuse;
  wire [6:0] ra, wa;
  wire [7:0] wd;
  wire sda = ~(m_low | (oe & ~sda_o)); // Pull-up on the wire
  always #50 clk_in = ~clk_in;
  eetw_bm eetw_bm_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
  eetw_slave #(.WRITE_CYCLES(300)) eetw_slave_i (.clk_in(clk_in), .rst_in(rst_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(oe),
    .transmit_only_clock_in(txoc), .wp_n_in(wp_n), .arr_rd_data_in(rd_q),
    .arr_rd_addr_out(ra), .arr_wr_en_out(we), .arr_wr_addr_out(wa),
    .arr_wr_data_out(wd), .bidir_mode_out(bidir), .busy_out(busy), .fuse_out(fuse));
  always @(posedge clk_in)
  begin
    rd_q <= arr_q[ra];
    if (we) arr_q[wa] <= wd;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  function wr_permit(input t, input f, input w);
    wr_permit = t & (~f | w);
  endfunction
  function [6:0] slot_addr(input [7:0] a, input [2:0] k);
    slot_addr = {a[6:3], a[2:0] + k};
  endfunction
  task ctl(input rw, input [6:0] ad, input e);
    begin
      eetw_bm_i.start;
      eetw_bm_i.wbyte({ad, rw}, ak);
      `CHK("ack", e, ak)
    end
  endtask
  task wr(input [7:0] a, input integer n);
    reg ok;
    reg [7:0] d;
    integer k;
    begin
      @(posedge clk_in);
      ok = wr_permit(txoc, efuse, wp_n);
      ctl(1'b0, DEV, 1'b1);
      eetw_bm_i.wbyte(a, ak);
      `CHK("ack", 1'b1, ak)
      for (k = 0; k < n; k = k + 1)
      begin
        d = 8'($random(seed));
        eetw_bm_i.wbyte(d, ak);
        `CHK("ack", 1'b1, ak)
        if (ok) exp_mem[slot_addr(a, k[2:0])] = d;
      end
      if (ok && a[6:3] == 4'hf && 7 - a[2:0] < n) efuse = 1'b1;
      // Pointer moves even when the write is refused
      ptr = {a[7:3], a[2:0] + n[2:0]};
      eetw_bm_i.stop;
      repeat (2) @(posedge clk_in);
      #1;
      `CHK("busy", ok, busy)
    end
  endtask
  task fin;
    integer k;
    begin
      for (k = 0; busy === 1'b1 && k < 600; k = k + 1)
        @(posedge clk_in);
      #1;
      `CHK("busy", 1'b0, busy)
      `CHK("fuse", efuse, fuse)
      `CHK("sda_out", 1'b0, sda_o)
      for (k = 0; k < 128; k = k + 1)
        `CHK("mem", exp_mem[k], arr_q[k])
    end
  endtask
  task rd(input rnd, input [7:0] a, input integer n);
    reg [7:0] d;
    integer k;
    begin
      if (rnd)
      begin
        ctl(1'b0, DEV, 1'b1);
        eetw_bm_i.wbyte(a, ak);
        ptr = a;
      end
      ctl(1'b1, DEV, 1'b1);
      for (k = 0; k < n; k = k + 1)
      begin
        eetw_bm_i.rbyte(k != n - 1, d);
        `CHK("rd", exp_mem[ptr[6:0]], d)
        ptr = ptr + 8'h1;
      end
      `CHK("release", 1'b0, oe)
      eetw_bm_i.stop;
      `CHK("release", 1'b0, oe)
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    for (i = 0; i < 128; i = i + 1)
    begin
      arr_q[i] = 8'h00;
      exp_mem[i] = 8'h00;
    end
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    `CHK("mode", 1'b0, bidir)
    ctl(1'b0, DEV ^ 7'h01, 1'b0);
    eetw_bm_i.stop;
    `CHK("mode", 1'b1, bidir)
    $display("test mode done");
    wr(8'h13, 1);
    ctl(1'b0, DEV, 1'b0);
    eetw_bm_i.stop;
    fin;
    rd(1'b0, 8'h00, 2);
    $display("test byte done");
    wr(8'h45, 11);
    fin;
    rd(1'b0, 8'h00, 2);
    rd(1'b1, 8'h40, 8);
    $display("test page done");
    txoc <= 1'b0;
    wr(8'h20, 3);
    txoc <= 1'b1;
    fin;
    wr(8'h28, 2);
    txoc <= 1'b0;
    fin;
    txoc <= 1'b1;
    $display("test write enable done");
    wr(8'h7c, 4);
    fin;
    wp_n <= 1'b0;
    wr(8'h30, 1);
    fin;
    wp_n <= 1'b1;
    wr(8'h31, 1);
    fin;
    $display("test protect done");
    for (i = 0; i < 4; i = i + 1)
    begin
      r8 = 8'($random(seed));
      wr(r8, 1 + {$random(seed)} % 9);
      fin;
      rd(1'b1, r8, 3);
    end
    $display("test random done");
    tally_and_finish;
  end
endmodule // eetw_slave_tb

// ### verilog/eetw_defs.vh
// Constants for the two-wire EEPROM slave: timing, addresses, reset values.
// Assumes a 10 MHz system clock; included by eetw_slave.v and eetw_page_buf.v.
//
// Function
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - SDA changes only while SCL is low
// - Keep only the last eight bytes, FIFO
// - Bi-directional mode sticks until power loss
// - Acknowledge every received byte on ninth clock
// - No acknowledge while programming is busy
// - Hold SDA low through acknowledge high phase
// - Release SDA after master's read no-acknowledge
// - Seven-bit address then direction bit
// - Acknowledge only matching address when idle
// - Second byte loads word address pointer
// - STOP after data starts timed write
// - Write clock pin ignored once programming runs
// - Buffer eight page bytes, commit after STOP
// - Only low three address bits advance (on writes; reads carry through all eight bits)
// - Write clock pin low rejects all writes
// - Writing 7Fh sets permanent protection fuse
// - Fuse set and protect low: read-only
// - Current read returns last address plus one
// - Pointer advances by one per byte

`ifndef EETW_DEFS_VH
`define EETW_DEFS_VH

`define EETW_CLK_HZ 10000000
`define EETW_TWR_MS 10
`define EETW_TWR_CYCLES ((`EETW_TWR_MS * `EETW_CLK_HZ) / 1000)
`define EETW_TMR_W 17

// Arbitrary value, not tied to any real part
`define EETW_DEV_ADDR 7'h2b

`define EETW_FUSE_LOC 7'h7f
`define EETW_WA_W 8
`define EETW_PAGE_AW 3
`define EETW_BYTE_BITS 4'h8
`define EETW_PIN_RST 1'b1
`define EETW_WA_RST 8'h00

`endif

// ### verilog/eetw_page_buf.v
// Page buffer for the EEPROM slave: small RAM, one write and one read port.
// Assumes the caller holds addresses stable; read data lag the address by one clock.
`timescale 1ns/10ps
`include "eetw_defs.vh"

module eetw_page_buf #(
  parameter DW = 8,
  parameter AW = `EETW_PAGE_AW
) (
  input wire clk_in,
  input wire rst_in,
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [DW-1:0] wr_data_in,
  input wire [AW-1:0] rd_addr_in,
  output reg [DW-1:0] rd_data_out
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_data_out <= {DW{1'b0}};
    end
    else
    begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule // eetw_page_buf

// ### verilog/eetw_slave.v
// Two-wire slave logic of a small serial EEPROM in bi-directional mode.
// Assumes an external array: registered read address, data valid one clock
// later; writes are one-cycle strobes. Reset stands for power-up.
`timescale 1ns/10ps
`include "eetw_defs.vh"

module eetw_slave #(
  parameter WRITE_CYCLES = `EETW_TWR_CYCLES,
  parameter TMR_W = `EETW_TMR_W,
  parameter [6:0] DEV_ADDR = `EETW_DEV_ADDR
) (
  input wire clk_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_out,
  input wire transmit_only_clock_in,
  input wire wp_n_in,
  input wire [7:0] arr_rd_data_in,
  output reg [6:0] arr_rd_addr_out,
  output reg arr_wr_en_out,
  output reg [6:0] arr_wr_addr_out,
  output reg [7:0] arr_wr_data_out,
  output reg bidir_mode_out,
  output reg busy_out,
  output reg fuse_out
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_RXACK = 3'h2;
  localparam [2:0] ST_TX = 3'h3;
  localparam [2:0] ST_TXACK = 3'h4;
  localparam [2:0] ST_SKIP = 3'h5;

  localparam [1:0] IDX_CTRL = 2'h0;
  localparam [1:0] IDX_WORD = 2'h1;
  localparam [1:0] IDX_DATA = 2'h2;

  localparam integer TWR_LAST_I = WRITE_CYCLES - 1;
  localparam [TMR_W-1:0] TWR_LAST = TWR_LAST_I[TMR_W-1:0];

  // Next word address within the page: upper bits fixed
  function [7:0] page_inc;
    input [7:0] wa;
    begin
      page_inc = {wa[7:3], wa[2:0] + 3'h1};
    end
  endfunction

  // Pin synchronisers: change accepted once stages two and three agree
  wire [3:0] pin_raw;
  wire [3:0] pin_f;
  assign pin_raw = {wp_n_in, transmit_only_clock_in, sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg f_q;
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          s1_q <= `EETW_PIN_RST;
          s2_q <= `EETW_PIN_RST;
          s3_q <= `EETW_PIN_RST;
          f_q <= `EETW_PIN_RST;
        end
        else
        begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
          begin
            f_q <= s3_q;
          end
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  wire scl_f = pin_f[0];
  wire sda_f = pin_f[1];
  wire txoc_f = pin_f[2];
  wire wp_n_f = pin_f[3];

  reg scl_p_q;
  reg sda_p_q;
  wire scl_rise = scl_f & ~scl_p_q;
  wire scl_fall = ~scl_f & scl_p_q;
  wire start_det = bidir_mode_out & scl_f & scl_p_q & sda_p_q & ~sda_f;
  wire stop_det = bidir_mode_out & scl_f & scl_p_q & ~sda_p_q & sda_f;

  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [1:0] idx_q;
  reg rw_q;
  reg mack_q;
  reg [7:0] wa_q;
  reg wr_ok_q;
  reg [7:0] vld_q;
  reg [7:0] cm_vld_q;
  reg [4:0] cm_base_q;
  reg cm_act_q;
  reg [3:0] cm_q;
  reg [TMR_W-1:0] tmr_q;

  wire byte_done = (st_q == ST_RX) & scl_fall & (bit_q == `EETW_BYTE_BITS);
  wire pb_we = byte_done & (idx_q == IDX_DATA) & ~start_det & ~stop_det;
  wire [7:0] pb_rdata;
  wire [2:0] cm_slot = cm_q[2:0] - 3'h1;
  // Fuse gates the protect pin; open pin reads high and allows writes
  wire wr_allow = wr_ok_q & (~fuse_out | wp_n_f);

  eetw_page_buf #(
    .DW(8),
    .AW(`EETW_PAGE_AW)
  ) u_page_buf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_en_in(pb_we),
    .wr_addr_in(wa_q[2:0]),
    .wr_data_in(sh_q),
    .rd_addr_in(cm_q[2:0]),
    .rd_data_out(pb_rdata)
  );

  // Bus protocol engine
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      scl_p_q <= `EETW_PIN_RST;
      sda_p_q <= `EETW_PIN_RST;
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= IDX_CTRL;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      wa_q <= `EETW_WA_RST;
      wr_ok_q <= 1'b0;
      vld_q <= 8'h00;
      sda_oe_out <= 1'b0;
      sda_out <= 1'b0;
      bidir_mode_out <= 1'b0;
      arr_rd_addr_out <= 7'h00;
    end
    else
    begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      sda_out <= 1'b0;
      arr_rd_addr_out <= wa_q[6:0];
      // Only power-up clears this
      if (scl_fall)
      begin
        bidir_mode_out <= 1'b1;
      end
      // Write clock pin must stay high for the whole command
      if ((st_q != ST_IDLE) && !txoc_f)
      begin
        wr_ok_q <= 1'b0;
      end
      if (start_det)
      begin
        // Repeated START drops uncommitted page data
        st_q <= ST_RX;
        bit_q <= 4'h0;
        idx_q <= IDX_CTRL;
        sda_oe_out <= 1'b0;
        vld_q <= 8'h00;
        wr_ok_q <= txoc_f;
      end
      else if (stop_det)
      begin
        st_q <= ST_IDLE;
        sda_oe_out <= 1'b0;
        vld_q <= 8'h00;
      end
      else
      begin
        case (st_q)
          ST_RX:
          begin
            if (scl_rise)
            begin
              sh_q <= {sh_q[6:0], sda_f};
              bit_q <= bit_q + 4'h1;
            end
            else if (byte_done)
            begin
              bit_q <= 4'h0;
              if (idx_q == IDX_CTRL)
              begin
                rw_q <= sh_q[0];
                if ((sh_q[7:1] == DEV_ADDR) && !busy_out)
                begin
                  sda_oe_out <= 1'b1;
                  st_q <= ST_RXACK;
                end
                else
                begin
                  st_q <= ST_SKIP;
                end
              end
              else if (idx_q == IDX_WORD)
              begin
                wa_q <= sh_q;
                sda_oe_out <= 1'b1;
                st_q <= ST_RXACK;
              end
              else
              begin
                wa_q <= page_inc(wa_q);
                vld_q[wa_q[2:0]] <= 1'b1;
                sda_oe_out <= 1'b1;
                st_q <= ST_RXACK;
              end
            end
          end
          ST_RXACK:
          begin
            // Low held until SCL falls, covering the whole high phase
            if (scl_fall)
            begin
              if ((idx_q == IDX_CTRL) && rw_q)
              begin
                sh_q <= arr_rd_data_in;
                sda_oe_out <= ~arr_rd_data_in[7];
                bit_q <= 4'h1;
                st_q <= ST_TX;
              end
              else
              begin
                sda_oe_out <= 1'b0;
                st_q <= ST_RX;
                if (idx_q != IDX_DATA)
                begin
                  idx_q <= idx_q + 2'h1;
                end
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bit_q == `EETW_BYTE_BITS)
              begin
                sda_oe_out <= 1'b0;
                wa_q <= wa_q + 8'h01;
                st_q <= ST_TXACK;
              end
              else
              begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_out <= ~sh_q[6];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_TXACK:
          begin
            if (scl_rise)
            begin
              mack_q <= ~sda_f;
            end
            else if (scl_fall)
            begin
              if (mack_q)
              begin
                sh_q <= arr_rd_data_in;
                sda_oe_out <= ~arr_rd_data_in[7];
                bit_q <= 4'h1;
                st_q <= ST_TX;
              end
              else
              begin
                sda_oe_out <= 1'b0;
                st_q <= ST_SKIP;
              end
            end
          end
          ST_IDLE, ST_SKIP:
          begin
            sda_oe_out <= 1'b0;
          end
          default:
          begin
            st_q <= ST_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Self-timed write: decision frozen at STOP, so pins are ignored after
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      busy_out <= 1'b0;
      tmr_q <= {TMR_W{1'b0}};
      cm_act_q <= 1'b0;
      cm_q <= 4'h0;
      cm_vld_q <= 8'h00;
      cm_base_q <= 5'h00;
      arr_wr_en_out <= 1'b0;
      arr_wr_addr_out <= 7'h00;
      arr_wr_data_out <= 8'h00;
      fuse_out <= 1'b0;
    end
    else
    begin
      arr_wr_en_out <= 1'b0;
      if (stop_det && !busy_out && (|vld_q) && wr_allow)
      begin
        busy_out <= 1'b1;
        tmr_q <= {TMR_W{1'b0}};
        cm_act_q <= 1'b1;
        cm_q <= 4'h0;
        cm_vld_q <= vld_q;
        cm_base_q <= wa_q[7:3];
      end
      else if (busy_out)
      begin
        // Counts on regardless of the write clock pin
        tmr_q <= tmr_q + {{(TMR_W-1){1'b0}}, 1'b1};
        if (tmr_q == TWR_LAST)
        begin
          busy_out <= 1'b0;
        end
      end
      if (cm_act_q)
      begin
        cm_q <= cm_q + 4'h1;
        if (cm_q == `EETW_BYTE_BITS)
        begin
          cm_act_q <= 1'b0;
        end
        if (cm_q != 4'h0)
        begin
          arr_wr_en_out <= cm_vld_q[cm_slot];
          arr_wr_addr_out <= {cm_base_q[3:0], cm_slot};
          arr_wr_data_out <= pb_rdata;
          if (cm_vld_q[cm_slot] && ({cm_base_q[3:0], cm_slot} == `EETW_FUSE_LOC))
          begin
            fuse_out <= 1'b1;
          end
        end
      end
    end
  end

endmodule // eetw_slave
